// ---- verilog/lnk_consts.svh ----
`ifndef LNK_CONSTS_SVH
`define LNK_CONSTS_SVH
// Purpose: Offsets, fields, reset values and timing counts of the token link
// Assumes: 40 MHz sys_clk, 32-bit words sent as eight nibbles
// Notes:   Functional notes below
//
// Functional notes
// - Exactly one port holds the token after reset
// - Slave asks by raising its acknowledge line
// - Master sends release word, then drops token
// - Slave takes token when release word matches while it wants the token
// - Mismatching word stays ordinary received data
// - Master may offer token without any request
// - Never two transmitters on one link
// - Old master receives before new master transmits
// - Token passes only if drained before timeout
// - Slave request raises service request at master
// - Unmasked request status rise latches service request
// - Acknowledge low withholds next word, not current
// - Receive read stalls until a word arrives
// - Assignment register written before control register
// - Tx request = acknowledge, tx mask, not enabled
// - Rx request = link clock, rx mask, not enabled

`define LNK_CLK_NS    25
`define LNK_HALF_NS   100
`define LNK_HALF_CYC  ((`LNK_HALF_NS + `LNK_CLK_NS - 1) / `LNK_CLK_NS)
`define LNK_TMO_NS    2000
`define LNK_TMO_CYC   (`LNK_TMO_NS / `LNK_CLK_NS)
`define LNK_HOLD_NS   3000
`define LNK_HOLD_CYC  ((`LNK_HOLD_NS + `LNK_CLK_NS - 1) / `LNK_CLK_NS)
`define LNK_TURN_NS   200
`define LNK_TURN_CYC  ((`LNK_TURN_NS + `LNK_CLK_NS - 1) / `LNK_CLK_NS)
`define LNK_LAST_NIB  3'h7

`define LNK_REG_CTRL    8'h00
`define LNK_REG_STAT    8'h04
`define LNK_REG_TXD     8'h08
`define LNK_REG_RXD     8'h0C
`define LNK_REG_REL     8'h10
`define LNK_REG_ASSIGN  8'h14
`define LNK_REG_IRQ_ST  8'h18
`define LNK_REG_IRQ_EN  8'h1C
`define LNK_REG_IRQ_CLR 8'h20

`define LNK_CTRL_EN    0
`define LNK_CTRL_TXM   1
`define LNK_CTRL_RXM   2
`define LNK_CTRL_WANT  3
`define LNK_CTRL_GIVE  4
`define LNK_IRQ_W      5
`define LNK_REL_RST    32'h5AA5_C33C
`endif

// ---- verilog/lnk_pkg.sv ----
// Purpose: Types shared by both link ends
// Assumes: Nothing
// Notes:   Roles of one link port in the token handover
package lnk_pkg;
    typedef enum logic [2:0] {
        S_RX,
        S_TX,
        S_REL,
        S_WAIT,
        S_HOLD,
        S_TURN
    } lnk_state_type;
endpackage : lnk_pkg

// ---- verilog/lnk_if.sv ----
// Purpose: Point-to-point nibble link between the device end and far end
// Assumes: Undriven lines read low, as with pulldowns
// Notes:   Lines resolved from each end's value and enable
interface lnk_if;
    logic       dev_clk_o;
    logic       dev_clk_oe;
    logic [3:0] dev_dat_o;
    logic       dev_dat_oe;
    logic       dev_ack_o;
    logic       dev_ack_oe;
    logic       far_clk_o;
    logic       far_clk_oe;
    logic [3:0] far_dat_o;
    logic       far_dat_oe;
    logic       far_ack_o;
    logic       far_ack_oe;
    logic       link_clock_line;
    logic       link_ack_line;
    logic [3:0] link_data;

    assign link_clock_line = (dev_clk_oe & dev_clk_o) | (far_clk_oe & far_clk_o);
    assign link_ack_line   = (dev_ack_oe & dev_ack_o) | (far_ack_oe & far_ack_o);
    assign link_data       = ({4{dev_dat_oe}} & dev_dat_o) | ({4{far_dat_oe}} & far_dat_o);

    modport dev (
        output dev_clk_o, dev_clk_oe, dev_dat_o, dev_dat_oe, dev_ack_o, dev_ack_oe,
        input  link_clock_line, link_ack_line, link_data
    );
    modport far (
        output far_clk_o, far_clk_oe, far_dat_o, far_dat_oe, far_ack_o, far_ack_oe,
        input  link_clock_line, link_ack_line, link_data
    );
endinterface : lnk_if

// ---- verilog/lnk_port.sv ----
// Purpose: One link port: nibble serdes and token handover sequencer
// Assumes: Link pins asynchronous to sys_clk
// Notes:   Used by both ends of the link
//
// Implementation choices: the placing of the registers and the strobed register port.
`include "lnk_consts.svh"
module lnk_port (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Control
    input  wire logic        orig_master,
    input  wire logic        enable,
    input  wire logic        want,
    input  wire logic        give,
    input  wire logic [31:0] release_word,
    // Words
    input  wire logic        tx_load,
    input  wire logic [31:0] tx_word,
    output logic             tx_full,
    output logic [31:0]      rx_word,
    output logic             rx_full,
    input  wire logic        rx_taken,
    // Status and events
    output logic             token,
    output logic             ack_level,
    output logic             clk_level,
    output logic             evt_given,
    output logic             evt_kept,
    output logic             evt_taken,
    output logic             evt_rx,
    // Link pins
    input  wire logic        clk_in,
    input  wire logic        ack_in,
    input  wire logic [3:0]  dat_in,
    output logic             clk_o,
    output logic             clk_oe,
    output logic [3:0]       dat_o,
    output logic             dat_oe,
    output logic             ack_o,
    output logic             ack_oe
);
    lnk_pkg::lnk_state_type state, next_state;
    logic [5:0]  s1, s2, s3, filt;
    logic        clk_prev, init_done, tx_busy, phase;
    logic [7:0]  div, cnt;
    logic [2:0]  tx_cnt, rx_cnt;
    logic [31:0] tx_sh, tx_hold, rx_sh;

    // Three-stage sampling; a change counts once stages two and three agree
    wire [5:0] agree     = ~(s2 ^ s3);
    wire [5:0] next_filt = (filt & ~agree) | (s2 & agree);
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s1 <= 6'h00; s2 <= 6'h00; s3 <= 6'h00; filt <= 6'h00; clk_prev <= 1'b0;
        end else begin
            s1 <= {ack_in, clk_in, dat_in};
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
            clk_prev <= filt[4];
        end
    end
    assign ack_level = filt[5];
    assign clk_level = filt[4];
    wire clk_rise = filt[4] & ~clk_prev;

    // Half-period enable of the link clock
    wire tick = (div == 8'(`LNK_HALF_CYC - 1));
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) div <= 8'h00;
        else div <= tick ? 8'h00 : div + 8'h01;
    end

    wire rx_mode  = (state == lnk_pkg::S_RX);
    wire driving  = enable & (state == lnk_pkg::S_TX | state == lnk_pkg::S_REL
                              | state == lnk_pkg::S_WAIT);
    wire tx_idle  = ~tx_busy & driving & ack_level & tick;
    wire go_data  = tx_idle & (state == lnk_pkg::S_TX) & tx_full;
    wire go_rel   = tx_idle & (state == lnk_pkg::S_REL);
    wire [31:0] rx_next = {filt[3:0], rx_sh[31:4]};
    wire word_end = rx_mode & clk_rise & (rx_cnt == `LNK_LAST_NIB);
    wire match    = want & (rx_next == release_word);
    wire next_ack = (state == lnk_pkg::S_HOLD)
                    | (rx_mode & ~rx_full & (enable | want));

    // Transmit: data set on one tick, clock high next tick, low and shift after
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_busy <= 1'b0; phase <= 1'b0; tx_cnt <= 3'h0; tx_sh <= 32'h0000_0000;
        end else if (go_data | go_rel) begin
            tx_busy <= 1'b1;
            phase <= 1'b0;
            tx_cnt <= 3'h0;
            tx_sh <= go_rel ? release_word : tx_hold;
        end else if (tx_busy & tick) begin
            phase <= ~phase;
            if (phase) begin
                tx_sh <= {4'h0, tx_sh[31:4]};
                tx_cnt <= tx_cnt + 3'h1;
                tx_busy <= (tx_cnt != `LNK_LAST_NIB);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_full <= 1'b0; tx_hold <= 32'h0000_0000;
        end else if (tx_load & ~tx_full) begin
            tx_full <= 1'b1; tx_hold <= tx_word;
        end else if (go_data) begin
            tx_full <= 1'b0;
        end
    end

    // Receive one nibble per link clock rise
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_sh <= 32'h0000_0000; rx_cnt <= 3'h0; rx_full <= 1'b0;
            rx_word <= 32'h0000_0000; evt_rx <= 1'b0;
        end else begin
            if (!rx_mode) rx_cnt <= 3'h0;
            else if (clk_rise) begin
                rx_sh <= rx_next;
                rx_cnt <= rx_cnt + 3'h1;
            end
            if (word_end & ~match) begin
                rx_full <= 1'b1;
                rx_word <= rx_next;
            end else if (rx_taken) rx_full <= 1'b0;
            evt_rx <= word_end & ~match;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            lnk_pkg::S_TX:   if (give) next_state = lnk_pkg::S_REL;
            lnk_pkg::S_REL:  if (go_rel) next_state = lnk_pkg::S_WAIT;
            lnk_pkg::S_WAIT: if (!tx_busy && !ack_level) next_state = lnk_pkg::S_TX;
                else if (!tx_busy && cnt == 8'(`LNK_TMO_CYC - 1))
                    next_state = lnk_pkg::S_RX;
            lnk_pkg::S_RX:   if (word_end && match) next_state = lnk_pkg::S_HOLD;
            lnk_pkg::S_HOLD: if (cnt == 8'(`LNK_HOLD_CYC - 1)) next_state = lnk_pkg::S_TURN;
            lnk_pkg::S_TURN: if (ack_level && cnt >= 8'(`LNK_TURN_CYC - 1))
                    next_state = lnk_pkg::S_TX;
            default:         next_state = lnk_pkg::S_RX;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= lnk_pkg::S_RX; token <= 1'b0; init_done <= 1'b0; cnt <= 8'h00;
            evt_given <= 1'b0; evt_kept <= 1'b0; evt_taken <= 1'b0;
        end else if (!init_done) begin
            init_done <= 1'b1;
            token <= orig_master;
            state <= orig_master ? lnk_pkg::S_TX : lnk_pkg::S_RX;
        end else begin
            state <= next_state;
            if (next_state != state || tx_busy) cnt <= 8'h00;
            else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
            if (state == lnk_pkg::S_WAIT && next_state == lnk_pkg::S_RX) token <= 1'b0;
            if (state == lnk_pkg::S_HOLD && next_state == lnk_pkg::S_TURN) token <= 1'b1;
            evt_given <= state == lnk_pkg::S_WAIT && next_state == lnk_pkg::S_RX;
            evt_kept  <= state == lnk_pkg::S_WAIT && next_state == lnk_pkg::S_TX;
            evt_taken <= state == lnk_pkg::S_HOLD && next_state == lnk_pkg::S_TURN;
        end
    end

    // Pins registered; only a transmitting role drives clock and data
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            clk_o <= 1'b0; clk_oe <= 1'b0; dat_o <= 4'h0; dat_oe <= 1'b0;
            ack_o <= 1'b0; ack_oe <= 1'b0;
        end else begin
            clk_o <= tx_busy & phase;
            dat_o <= tx_sh[3:0];
            clk_oe <= driving;
            dat_oe <= driving;
            ack_o <= next_ack;
            ack_oe <= rx_mode | (state == lnk_pkg::S_HOLD);
        end
    end
endmodule : lnk_port

// ---- verilog/lnk_dev.sv ----
// Purpose: Device end of the token link with its software register file
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes:   Reads of the receive register stall the core while empty
`include "lnk_consts.svh"
module lnk_dev (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Strap
    input  wire logic        orig_master,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    output logic             core_stall,
    // Interrupt
    output logic             irq,
    // Link
    lnk_if.dev               link
);
    // Control state
    logic                  link_buffer_enable;
    logic                  tx_request_mask;
    logic                  rx_request_mask;
    logic                  want;
    logic                  give;
    logic                  assign_done;
    logic [1:0]            link_assignment_reg;
    logic [31:0]           release_word;
    logic                  req_prev;
    logic [`LNK_IRQ_W-1:0] irq_st;
    logic [`LNK_IRQ_W-1:0] irq_en;

    // Port status
    logic        tx_full;
    logic        rx_full;
    logic [31:0] rx_word;
    logic        token;
    logic        ack_level;
    logic        clk_level;
    logic        evt_given;
    logic        evt_kept;
    logic        evt_taken;
    logic        evt_rx;

    // Address decode
    wire wr_ctrl   = reg_write & (reg_addr == `LNK_REG_CTRL);
    wire wr_txd    = reg_write & (reg_addr == `LNK_REG_TXD);
    wire wr_rel    = reg_write & (reg_addr == `LNK_REG_REL);
    wire wr_assign = reg_write & (reg_addr == `LNK_REG_ASSIGN);
    wire wr_irq_en = reg_write & (reg_addr == `LNK_REG_IRQ_EN);
    wire wr_clr    = reg_write & (reg_addr == `LNK_REG_IRQ_CLR);
    wire rd_rxd    = reg_read & (reg_addr == `LNK_REG_RXD);

    // Request status as seen by software
    wire tx_request_status = ack_level & tx_request_mask & ~link_buffer_enable;
    wire rx_request_status = clk_level & rx_request_mask & ~link_buffer_enable;
    wire req_any           = tx_request_status | rx_request_status;
    wire srq_rise          = req_any & ~req_prev;

    // Receive read takes the word now, or stalls until one lands
    wire rx_now    = rd_rxd & rx_full;
    wire rx_late   = core_stall & rx_full;
    wire rx_taken  = rx_now | rx_late;
    wire stall_set = rd_rxd & ~rx_full;

    // Interrupt events and clears; a set in the clear cycle survives
    wire [`LNK_IRQ_W-1:0] irq_evt = {evt_taken, evt_kept, evt_given, evt_rx, srq_rise};
    wire [`LNK_IRQ_W-1:0] irq_clr = wr_clr ? reg_wdata[`LNK_IRQ_W-1:0]
                                           : {`LNK_IRQ_W{1'b0}};
    wire [`LNK_IRQ_W-1:0] next_irq_st = (irq_st & ~irq_clr) | irq_evt;

    // Read multiplexer
    wire [31:0] ctrl_view = {27'h0, 1'b0, want, rx_request_mask, tx_request_mask,
                             link_buffer_enable};
    wire [31:0] stat_view = {26'h0, ~(token ^ link_buffer_enable) & give, rx_full,
                             tx_full, rx_request_status, tx_request_status, token};
    logic [31:0] next_rdata;
    always_comb begin
        case (reg_addr)
            `LNK_REG_CTRL:    next_rdata = ctrl_view;
            `LNK_REG_STAT:    next_rdata = stat_view;
            `LNK_REG_RXD:     next_rdata = rx_word;
            `LNK_REG_REL:     next_rdata = release_word;
            `LNK_REG_ASSIGN:  next_rdata = {30'h0, link_assignment_reg};
            `LNK_REG_IRQ_ST:  next_rdata = {27'h0, irq_st};
            `LNK_REG_IRQ_EN:  next_rdata = {27'h0, irq_en};
            default:          next_rdata = 32'h0000_0000;
        endcase
    end

    // Assignment first; control enable is refused until a nonzero assignment is written
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            link_assignment_reg <= 2'h0;
            assign_done <= 1'b0;
        end else if (wr_assign) begin
            link_assignment_reg <= reg_wdata[1:0];
            assign_done <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            link_buffer_enable <= 1'b0;
            tx_request_mask <= 1'b0;
            rx_request_mask <= 1'b0;
            want <= 1'b0;
        end else if (wr_ctrl) begin
            link_buffer_enable <= reg_wdata[`LNK_CTRL_EN] & assign_done
                                  & (link_assignment_reg != 2'h0);
            tx_request_mask <= reg_wdata[`LNK_CTRL_TXM];
            rx_request_mask <= reg_wdata[`LNK_CTRL_RXM];
            want <= reg_wdata[`LNK_CTRL_WANT];
        end else if (evt_taken) begin
            want <= 1'b0;
        end
    end

    // Give command is a one-cycle pulse to the port
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) give <= 1'b0;
        else give <= wr_ctrl & reg_wdata[`LNK_CTRL_GIVE];
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) release_word <= `LNK_REL_RST;
        else if (wr_rel) release_word <= reg_wdata;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            req_prev <= 1'b0;
            irq_st <= {`LNK_IRQ_W{1'b0}};
            irq_en <= {`LNK_IRQ_W{1'b0}};
            irq <= 1'b0;
        end else begin
            req_prev <= req_any;
            irq_st <= next_irq_st;
            if (wr_irq_en) irq_en <= reg_wdata[`LNK_IRQ_W-1:0];
            irq <= |(next_irq_st & (wr_irq_en ? reg_wdata[`LNK_IRQ_W-1:0] : irq_en));
        end
    end

    // Read data and receive stall
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
            core_stall <= 1'b0;
        end else begin
            if (rx_late) reg_rdata <= rx_word;
            else if (reg_read) reg_rdata <= stall_set ? 32'h0000_0000 : next_rdata;
            if (stall_set) core_stall <= 1'b1;
            else if (rx_late) core_stall <= 1'b0;
        end
    end

    lnk_port i_lnk_port (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .orig_master  (orig_master),
        .enable       (link_buffer_enable),
        .want         (want),
        .give         (give),
        .release_word (release_word),
        .tx_load      (wr_txd),
        .tx_word      (reg_wdata),
        .tx_full      (tx_full),
        .rx_word      (rx_word),
        .rx_full      (rx_full),
        .rx_taken     (rx_taken),
        .token        (token),
        .ack_level    (ack_level),
        .clk_level    (clk_level),
        .evt_given    (evt_given),
        .evt_kept     (evt_kept),
        .evt_taken    (evt_taken),
        .evt_rx       (evt_rx),
        .clk_in       (link.link_clock_line),
        .ack_in       (link.link_ack_line),
        .dat_in       (link.link_data),
        .clk_o        (link.dev_clk_o),
        .clk_oe       (link.dev_clk_oe),
        .dat_o        (link.dev_dat_o),
        .dat_oe       (link.dev_dat_oe),
        .ack_o        (link.dev_ack_o),
        .ack_oe       (link.dev_ack_oe)
    );
endmodule : lnk_dev

// ---- verilog/lnk_far.sv ----
// Purpose: Far end of the token link, driven by plain user ports
// Assumes: User loads words only while tx_full is low
// Notes:   Request for the token is the want_token level
`include "lnk_consts.svh"
module lnk_far (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Control
    input  wire logic        orig_master,
    input  wire logic        enable,
    input  wire logic        want_token,
    input  wire logic        give_token,
    input  wire logic [31:0] release_word,
    // Transmit words
    input  wire logic        tx_load,
    input  wire logic [31:0] tx_word,
    output logic             tx_full,
    // Receive words
    output logic [31:0]      rx_word,
    output logic             rx_full,
    input  wire logic        rx_taken,
    // Status
    output logic             token,
    output logic             token_taken,
    output logic             token_kept,
    // Link
    lnk_if.far               link
);
    lnk_port i_lnk_port (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .orig_master  (orig_master),
        .enable       (enable),
        .want         (want_token),
        .give         (give_token),
        .release_word (release_word),
        .tx_load      (tx_load),
        .tx_word      (tx_word),
        .tx_full      (tx_full),
        .rx_word      (rx_word),
        .rx_full      (rx_full),
        .rx_taken     (rx_taken),
        .token        (token),
        .ack_level    (),
        .clk_level    (),
        .evt_given    (),
        .evt_kept     (token_kept),
        .evt_taken    (token_taken),
        .evt_rx       (),
        .clk_in       (link.link_clock_line),
        .ack_in       (link.link_ack_line),
        .dat_in       (link.link_data),
        .clk_o        (link.far_clk_o),
        .clk_oe       (link.far_clk_oe),
        .dat_o        (link.far_dat_o),
        .dat_oe       (link.far_dat_oe),
        .ack_o        (link.far_ack_o),
        .ack_oe       (link.far_ack_oe)
    );
endmodule : lnk_far

// ---- test/lnk_monitor.sv ----
// Purpose: Wire checks on the token link between both ends
// Assumes: One sys_clk domain, reset active high
// Notes:   Sees only the shared link signals
module lnk_monitor (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       reset,
    // Drive enables
    input wire logic       dev_clk_oe,
    input wire logic       far_clk_oe,
    input wire logic       dev_dat_oe,
    input wire logic       far_dat_oe,
    input wire logic       dev_ack_oe,
    input wire logic       far_ack_oe,
    // Resolved lines
    input wire logic       link_clock_line,
    input wire logic [3:0] link_data
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic       clk_q;
    logic [2:0] nib_cnt;
    wire        clk_rise = link_clock_line & ~clk_q;
    // Nibbles of the word in flight
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            clk_q   <= 1'b0;
            nib_cnt <= 3'h0;
        end else begin
            clk_q   <= link_clock_line;
            nib_cnt <= nib_cnt + {2'h0, clk_rise};
        end
    end
    sequence seq_high_phase;
        link_clock_line[*4] ##1 !link_clock_line;
    endsequence
    a_one_clock: assert property (!(dev_clk_oe && far_clk_oe))
        else $error("both ends drive the link clock");
    a_one_data: assert property (!(dev_dat_oe && far_dat_oe))
        else $error("both ends drive the link data");
    a_dev_tx_quiet: assert property (dev_clk_oe |-> !dev_ack_oe)
        else $error("device drives ack while transmitting");
    a_far_tx_quiet: assert property (far_clk_oe |-> !far_ack_oe)
        else $error("far end drives ack while transmitting");
    a_clock_has_data: assert property ($rose(link_clock_line) |-> dev_dat_oe || far_dat_oe)
        else $error("clock pulse without a data driver");
    a_far_turn: assert property ($rose(far_clk_oe) |-> !$past(dev_clk_oe, 8))
        else $error("far end transmits too soon after device");
    a_dev_turn: assert property ($rose(dev_clk_oe) |-> !$past(far_clk_oe, 8))
        else $error("device transmits too soon after far end");
    a_pulse_width: assert property ($rose(link_clock_line) |-> seq_high_phase)
        else $error("link clock high phase not four cycles");
    a_word_ends: assert property (nib_cnt != 3'h0 && !link_clock_line |-> ##[1:5] link_clock_line)
        else $error("word stopped before its last nibble");
    a_data_steady: assert property (link_clock_line && $past(link_clock_line) |-> $stable(link_data))
        else $error("link data moved while clock high");
endmodule : lnk_monitor

// ---- test/test_link_token_passing.sv ----
// Purpose: Self-checking bench for both ends of the token link
// Assumes: Device end starts with the token
// Notes:   Register reads and far receive words checked from queues
`include "lnk_consts.svh"
`define CHK(nm, got, exp) begin logic [31:0] e_v; e_v = 32'(exp); checked++; \
    if ((got) !== e_v) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", nm, e_v, got); end end
module test_link_token_passing;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 0, reset = 1, reg_write = 0, reg_read = 0, want = 0;
    logic        tx_load = 0, rx_taken = 0, stall_seen = 0;
    logic        core_stall, irq, f_tx_full, f_rx_full, f_token;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, tx_word = 32'h0, reg_rdata, f_rx_word, w;
    logic [31:0] reg_q[$], far_q[$];
    int          err_total = 0, checked = 0, n, k;
    lnk_if i_lnk_if ();
    lnk_dev i_lnk_dev (.sys_clk(sys_clk), .reset(reset), .orig_master(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .core_stall(core_stall), .irq(irq), .link(i_lnk_if));
    lnk_far i_lnk_far (.sys_clk(sys_clk), .reset(reset), .orig_master(1'b0), .enable(1'b1),
        .want_token(want), .give_token(1'b0), .release_word(`LNK_REL_RST), .tx_load(tx_load),
        .tx_word(tx_word), .tx_full(f_tx_full), .rx_word(f_rx_word), .rx_full(f_rx_full),
        .rx_taken(rx_taken), .token(f_token), .token_taken(), .token_kept(), .link(i_lnk_if));
    lnk_monitor i_lnk_monitor (.sys_clk(sys_clk), .reset(reset),
        .dev_clk_oe(i_lnk_if.dev_clk_oe), .far_clk_oe(i_lnk_if.far_clk_oe),
        .dev_dat_oe(i_lnk_if.dev_dat_oe), .far_dat_oe(i_lnk_if.far_dat_oe),
        .dev_ack_oe(i_lnk_if.dev_ack_oe), .far_ack_oe(i_lnk_if.far_ack_oe),
        .link_clock_line(i_lnk_if.link_clock_line), .link_data(i_lnk_if.link_data));
    always #12.5 sys_clk = ~sys_clk;
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    task automatic bound(input int cnt);
        if (cnt >= 1000) begin
            err_total++;
            close_out();
        end
    endtask : bound
    // One bus cycle; a read notes its expected data
    task automatic op(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= wr;
        reg_read  <= ~wr;
        if (!wr) reg_q.push_back(d);
        @(posedge sys_clk);
        reg_write <= 1'b0;
        reg_read  <= 1'b0;
    endtask : op
    // Read data stand the cycle after the strobe or after the stall
    initial forever begin
        @(posedge sys_clk);
        if (reg_read === 1'b1) begin
            @(negedge sys_clk);
            for (k = 0; k < 1000 && core_stall === 1'b1; k++) begin
                stall_seen = 1'b1;
                @(negedge sys_clk);
            end
            bound(k);
            `CHK("reg_rdata", reg_rdata, reg_q.pop_front())
        end
    end
    initial forever begin
        @(posedge sys_clk);
        if (f_rx_full === 1'b1 && rx_taken === 1'b0) begin
            `CHK("far rx_word", f_rx_word, far_q.pop_front())
            rx_taken <= 1'b1;
        end else begin
            rx_taken <= 1'b0;
        end
    end
    initial begin
        void'($urandom(2));
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        op(0, `LNK_REG_STAT, 32'h1);
        op(0, `LNK_REG_REL, `LNK_REL_RST);
        op(0, 8'hFC, 32'h0);
        op(1, `LNK_REG_CTRL, 32'h1);
        op(0, `LNK_REG_CTRL, 32'h0);
        op(1, `LNK_REG_ASSIGN, 32'h1);
        op(1, `LNK_REG_CTRL, 32'h1);
        op(0, `LNK_REG_CTRL, 32'h1);
        $display("test registers done");
        want <= 1'b1;
        repeat (3) begin
            w = $urandom;
            far_q.push_back(w);
            op(1, `LNK_REG_TXD, w);
            for (n = 0; n < 1000 && far_q.size() != 0; n++)
                @(posedge sys_clk);
            bound(n);
        end
        `CHK("far token", f_token, 1'b0)
        $display("test data done");
        op(1, `LNK_REG_CTRL, 32'h2);
        repeat (10) @(posedge sys_clk);
        op(0, `LNK_REG_STAT, 32'h3);
        op(0, `LNK_REG_IRQ_ST, 32'h1);
        op(1, `LNK_REG_IRQ_EN, 32'h1);
        repeat (2) @(negedge sys_clk);
        `CHK("irq", irq, 1'b1)
        op(1, `LNK_REG_IRQ_EN, 32'h0);
        repeat (2) @(negedge sys_clk);
        `CHK("irq", irq, 1'b0)
        op(1, `LNK_REG_IRQ_CLR, 32'h1F);
        op(0, `LNK_REG_IRQ_ST, 32'h0);
        $display("test request done");
        op(1, `LNK_REG_CTRL, 32'h11);
        for (n = 0; n < 1000 && f_token !== 1'b1; n++)
            @(posedge sys_clk);
        bound(n);
        want <= 1'b0;
        op(0, `LNK_REG_STAT, 32'h0);
        op(0, `LNK_REG_IRQ_ST, 32'h4);
        w = $urandom;
        tx_word <= w;
        tx_load <= 1'b1;
        @(posedge sys_clk);
        tx_load <= 1'b0;
        op(0, `LNK_REG_RXD, w);
        for (n = 0; n < 1000 && reg_q.size() != 0; n++)
            @(posedge sys_clk);
        bound(n);
        `CHK("stall seen", stall_seen, 1'b1)
        `CHK("far tx_full", f_tx_full, 1'b0)
        $display("test handover done");
        close_out();
    end
endmodule : test_link_token_passing
